// [bench/scsi_bus_model.sv]
`timescale 1ns/10ps
module scsi_bus_model (
    input  wire logic                      clk,
    input  wire scsi_regs_pkg::bus_lines_t ctl,
    input  wire logic                      role,
    input  wire logic                      hs_on,
    input  wire logic                      par_flip,
    input  wire logic [7:0]                sdb_out,
    output scsi_regs_pkg::bus_lines_t      bus_in
);
    logic       hs;
    logic [7:0] got[$];
    int         gap;
    initial begin
        hs = 1'b0;
        gap = 2;
        forever begin
            @(negedge clk);
            if (hs_on) begin
                hs = 1'b1;
                repeat (6) @(negedge clk);
                got.push_back(sdb_out);
                hs = 1'b0;
                repeat (gap) @(negedge clk);
                // alternate a prompt and a slow far side
                gap = (gap == 2) ? 9 : 2;
            end
        end
    end
    always_comb begin
        bus_in = ctl;
        bus_in.req = ctl.req | (hs & ~role);
        bus_in.ack = ctl.ack | (hs & role);
        bus_in.par = (~^ctl.data) ^ par_flip;
    end
endmodule

// [bench/scsi_phase_and_dma_start_regs_test.sv]
`timescale 1ns/10ps
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
module scsi_phase_and_dma_start_regs_test;
    logic                      clk, rst_n, cpu_rd, cpu_wr, dma_valid, dma_last, dma_ready, role, en, burst;
    logic                      pce, sdb_oe_n, par_out, req_oe_n, msg_oe_n, cd_oe_n, io_oe_n, irq, bact;
    logic                      hs_on, par_flip;
    logic [2:0]                cpu_addr;
    logic [7:0]                wdata, rdata, dma_data, sdb_out, rv;
    logic [7:0]                b[4];
    logic [31:0]               r32;
    scsi_regs_pkg::bus_lines_t ctl, bus_in;
    scsi_regs_pkg::dma_state_t st, exp_st;
    int                        n_mismatch, num_checks, cycles, seed, i;
    scsi_phase_regs scsi_phase_regs_inst (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .cpu_addr(cpu_addr),
        .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(wdata), .cpu_rdata(rdata), .responder_role(role),
        .dma_enable_bit(en), .burst_dma(burst), .parity_check_enable(pce), .dma_valid(dma_valid),
        .dma_ready(dma_ready), .dma_data(dma_data), .dma_last(dma_last), .bus_in(bus_in), .sdb_out(sdb_out),
        .sdb_oe_n(sdb_oe_n), .bus_parity_line_out(par_out), .req_oe_n(req_oe_n), .msg_oe_n(msg_oe_n),
        .cd_oe_n(cd_oe_n), .io_oe_n(io_oe_n), .interrupt_out(irq), .dma_state(st), .dma_burst_active(bact));
    scsi_bus_model scsi_bus_model_inst (.clk(clk), .ctl(ctl), .role(role), .hs_on(hs_on),
        .par_flip(par_flip), .sdb_out(sdb_out), .bus_in(bus_in));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    function automatic scsi_regs_pkg::dma_state_t exp_start(input int a, input logic r, input logic e);
        if (!e) return scsi_regs_pkg::DMA_IDLE;
        if (a == 5) return scsi_regs_pkg::DMA_SEND;
        if (a == 6) return r ? scsi_regs_pkg::DMA_TRECV : scsi_regs_pkg::DMA_IDLE;
        return r ? scsi_regs_pkg::DMA_IDLE : scsi_regs_pkg::DMA_IRECV;
    endfunction
    task automatic reset_dut();
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk);
        cpu_addr = a;
        wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(negedge clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        rv = rdata;
    endtask
    task automatic wait_irq();
        for (int k = 0; k < 10 && irq !== 1'b1; k++) @(negedge clk);
    endtask
    task automatic push(input logic [7:0] d, input logic l);
        @(negedge clk);
        dma_valid = 1'b1;
        dma_data = d;
        dma_last = l;
        for (int k = 0; k < 400 && dma_ready !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        dma_valid = 1'b0;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // the whole run needs under two thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        {rst_n, cpu_addr, cpu_rd, cpu_wr, wdata, role, en, burst, pce, dma_valid} = '0;
        {dma_data, dma_last, hs_on, par_flip} = '0;
        ctl = '0;
        seed = 32'h48f7_7555;
        reset_dut();
        rd(3'h1);
        `CHK("unmapped read", 8'h00, rv)
        `CHK("irq after reset", 1'b0, irq)
        for (i = 0; i < 8; i++) begin
            r32 = $random(seed);
            role = r32[9];
            b[0] = {r32[7:3], i[2:0]};
            wr(3'h3, b[0]);
            `CHK("req drive", ~(b[0][3] & role), req_oe_n)
            `CHK("msg drive", ~(b[0][2] & role), msg_oe_n)
            `CHK("cd drive", ~(b[0][1] & role), cd_oe_n)
            `CHK("io drive", ~(b[0][0] & role), io_oe_n)
            rd(3'h3);
            `CHK("phase readback", {4'h0, b[0][3:0]}, rv)
        end
        for (i = 0; i < 8; i++) begin
            r32 = $random(seed);
            ctl = r32[16:0];
            repeat (4) @(negedge clk);
            rd(3'h4);
            b[1] = {ctl.rst, ctl.bsy, ctl.req, ctl.msg, ctl.cd, ctl.io, ctl.sel, ~^ctl.data};
            `CHK("bus status", b[1], rv)
        end
        $display("test registers done");
        ctl = '0;
        pce = 1'b1;
        reset_dut();
        wr(3'h4, 8'h20);
        par_flip = 1'b1;
        ctl.data = 8'h20;
        ctl.sel = 1'b1;
        wait_irq();
        `CHK("selection irq", 1'b1, irq)
        ctl.sel = 1'b0;
        par_flip = 1'b0;
        rd(3'h5);
        `CHK("selection parity error", 1'b1, rv[5])
        rd(3'h7);
        `CHK("clear read data", 8'h00, rv)
        `CHK("irq cleared", 1'b0, irq)
        rd(3'h5);
        `CHK("parity error cleared", 1'b0, rv[5])
        ctl.data = 8'h10;
        ctl.sel = 1'b1;
        repeat (10) @(negedge clk);
        `CHK("foreign id irq", 1'b0, irq)
        pce = 1'b0;
        par_flip = 1'b1;
        ctl.data = 8'h20;
        wait_irq();
        `CHK("selection irq unchecked", 1'b1, irq)
        rd(3'h5);
        `CHK("parity left unchecked", 1'b0, rv[5])
        par_flip = 1'b0;
        $display("test selection done");
        role = 1'b0;
        en = 1'b1;
        ctl = '0;
        ctl.bsy = 1'b1;
        ctl.cd = 1'b1;
        reset_dut();
        wr(3'h3, 8'h01);
        ctl.req = 1'b1;
        wait_irq();
        `CHK("mismatch irq", 1'b1, irq)
        rd(3'h7);
        {ctl.req, ctl.cd, ctl.io} = 3'b001;
        repeat (4) @(negedge clk);
        ctl.req = 1'b1;
        repeat (10) @(negedge clk);
        `CHK("matched phase irq", 1'b0, irq)
        $display("test mismatch done");
        // mode bits settled before any start write
        role = 1'b1;
        burst = 1'b1;
        ctl.req = 1'b0;
        reset_dut();
        for (i = 0; i < 3; i++) begin
            r32 = $random(seed);
            b[i] = r32[7:0];
        end
        b[3] = 8'hff;
        push(b[0], 1'b0);
        push(b[1], 1'b0);
        `CHK("full buffer refuses", 1'b0, dma_ready)
        wr(3'h5, 8'ha5);
        `CHK("send started", scsi_regs_pkg::DMA_SEND, st)
        `CHK("burst flag", 1'b1, bact)
        hs_on = 1'b1;
        push(b[2], 1'b0);
        `CHK("data driven", 1'b0, sdb_oe_n)
        push(b[3], 1'b1);
        for (i = 0; i < 400 && scsi_bus_model_inst.got.size() < 4; i++) @(negedge clk);
        hs_on = 1'b0;
        for (i = 0; i < 4; i++) `CHK("byte on bus", b[i], scsi_bus_model_inst.got[i])
        `CHK("bus parity", ~^b[3], par_out)
        rd(3'h3);
        `CHK("last byte flag", 1'b1, rv[7])
        `CHK("send finished", scsi_regs_pkg::DMA_IDLE, st)
        `CHK("data released", 1'b1, sdb_oe_n)
        $display("test send done");
        for (i = 0; i < 12; i++) begin
            r32 = $random(seed);
            role = i[0];
            en = i[1];
            burst = r32[8];
            reset_dut();
            wr(3'(5 + i / 4), r32[7:0]);
            @(negedge clk);
            exp_st = exp_start(5 + i / 4, role, en);
            `CHK("start state", exp_st, st)
            `CHK("burst active", burst & (exp_st != scsi_regs_pkg::DMA_IDLE), bact)
        end
        $display("test starts done");
        test_done();
    end
endmodule

// [common/scsi_regs_consts.svh]
// Overview of operation
// R1 - set phase register bit 7 once the final DMA byte is on the bus
// R2 - phase bit 3 drives REQ only in responder role; zero releases it
// R3 - phase bits 2..0 are MSG, C/D, I/O encoding the bus phase
// R4 - I/O driven only in responder role; high means data flows in
// R5 - initiator with DMA on: REQ with wrong phase raises mismatch interrupt
// R6 - bus status shows control lines and parity unlatched, one when asserted
// R7 - status bits: RST BSY REQ MSG C/D I/O SEL parity from 7 to 0
// R8 - bus parity is odd over eight data bits plus parity
// R9 - ID register at 4; free bus, SEL and ID match raise selection interrupt
// R10 - parity checked during selection only when parity_check_enable set
// R11 - read of 7 returns nothing and clears interrupt and error flags
// R12 - writes to DMA start registers trigger only; data ignored
// R13 - host sets DMA enable, burst mode and role before a start write
// R14 - write to 5 starts DMA send in either role with DMA enabled
// R15 - write to 6 starts responder receive; needs DMA enable and responder
// R16 - write to 7 starts initiator receive; needs DMA enable, not responder
// R17 - responder drives C/D, I/O, MSG, REQ; initiator role drives none here
// R18 - burst DMA lets the controller hold acknowledge and pace by ready; here burst_dma only raises dma_burst_active during a transfer
// R19 - three-bit address with read or write strobe selects distinct registers
// R20 - phase register bits 6..4 read zero and ignore writes
`ifndef SCSI_REGS_CONSTS_SVH
`define SCSI_REGS_CONSTS_SVH
`define ADDR_PHASE       3'h3
`define ADDR_BUS_ID      3'h4
`define ADDR_STAT_SEND   3'h5
`define ADDR_TRECV       3'h6
`define ADDR_CLR_IRECV   3'h7
`define PH_LAST_BIT      7
`define PH_REQ_BIT       3
`define ST_PARERR_BIT    5
`define ST_IRQ_BIT       4
`define ST_MATCH_BIT     3
`define ST_BUSYERR_BIT   2
`define ST_ACTIVE_BIT    0
`define PHASE_RESET      4'h0
`define ID_RESET         8'h00
`define FIFO_DEPTH       2
`endif

// [common/scsi_regs_pkg.sv]
package scsi_regs_pkg;
    typedef enum logic [1:0] {
        DMA_IDLE  = 2'b00,
        DMA_SEND  = 2'b01,
        DMA_TRECV = 2'b10,
        DMA_IRECV = 2'b11
    } dma_state_t;

    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } fifo_entry_t;

    // values are asserted-high views of the active-low bus lines
    typedef struct packed {
        logic       rst;
        logic       bsy;
        logic       req;
        logic       msg;
        logic       cd;
        logic       io;
        logic       sel;
        logic       ack;
        logic [7:0] data;
        logic       par;
    } bus_lines_t;
endpackage

// [verilog/scsi_phase_regs.sv]
`timescale 1ns/10ps
`include "scsi_regs_consts.svh"
module scsi_phase_regs (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [2:0]        cpu_addr,
    input  wire logic              cpu_rd,
    input  wire logic              cpu_wr,
    input  wire logic [7:0]        cpu_wdata,
    output logic      [7:0]        cpu_rdata,
    input  wire logic              responder_role,
    input  wire logic              dma_enable_bit,
    input  wire logic              burst_dma,
    input  wire logic              parity_check_enable,
    input  wire logic              dma_valid,
    output logic                   dma_ready,
    input  wire logic [7:0]        dma_data,
    input  wire logic              dma_last,
    input  wire scsi_regs_pkg::bus_lines_t bus_in,
    output logic      [7:0]        sdb_out,
    output logic                   sdb_oe_n,
    output logic                   bus_parity_line_out,
    output logic                   req_oe_n,
    output logic                   msg_oe_n,
    output logic                   cd_oe_n,
    output logic                   io_oe_n,
    output logic                   interrupt_out,
    output scsi_regs_pkg::dma_state_t dma_state,
    output logic                   dma_burst_active
);

    logic                         rst_meta;
    logic                         rst_n_int;
    scsi_regs_pkg::bus_lines_t    lines_meta;
    scsi_regs_pkg::bus_lines_t    lines;
    logic                         req_prev;
    logic                         hs_prev;
    logic                         bsy_prev;
    logic                         sel_prev;
    logic [3:0]                   phase_reg;
    logic                         last_byte_reg;
    logic [7:0]                   id_reg;
    logic                         irq_reg;
    logic                         parerr_reg;
    logic                         busyerr_reg;
    logic                         mismatch_reg;
    logic [7:0]                   rdata_reg;
    logic [7:0]                   sdb_reg;
    logic                         sdb_valid_reg;
    scsi_regs_pkg::dma_state_t    state_reg;
    scsi_regs_pkg::dma_state_t    state_next;
    scsi_regs_pkg::fifo_entry_t   fifo_mem [`FIFO_DEPTH];
    logic                         wr_ptr_reg;
    logic                         rd_ptr_reg;
    logic [1:0]                   count_reg;
    logic                         push;
    logic                         pop;
    logic                         fifo_empty;
    logic                         fifo_full;
    scsi_regs_pkg::fifo_entry_t   head;
    logic                         hs_line;
    logic                         hs_rise;
    logic                         req_rise;
    logic                         phase_diff;
    logic                         mismatch_evt;
    logic                         sel_cond;
    logic                         sel_evt;
    logic                         par_bad;
    logic                         par_evt;
    logic                         busy_evt;
    logic                         any_evt;
    logic                         clr_rd;
    logic                         wr_phase;
    logic                         wr_id;
    logic                         start_send;
    logic                         start_trecv;
    logic                         start_irecv;
    logic [7:0]                   bus_status;
    logic [7:0]                   dma_status;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta  <= 1'b0;
            rst_n_int <= 1'b0;
        end else begin
            rst_meta  <= 1'b1;
            rst_n_int <= rst_meta;
        end
    end

    // bus lines arrive asynchronously from other devices
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            lines_meta <= '0;
            lines      <= '0;
        end else if (clk_en) begin
            lines_meta <= bus_in;
            lines      <= lines_meta;
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            req_prev <= 1'b0;
            hs_prev  <= 1'b0;
            bsy_prev <= 1'b0;
            sel_prev <= 1'b0;
        end else if (clk_en) begin
            req_prev <= lines.req;
            hs_prev  <= hs_line;
            bsy_prev <= lines.bsy;
            sel_prev <= sel_cond;
        end
    end

    // register decode
    assign wr_phase    = cpu_wr && (cpu_addr == `ADDR_PHASE); // [R19]
    assign wr_id       = cpu_wr && (cpu_addr == `ADDR_BUS_ID); // [R19]
    assign clr_rd      = cpu_rd && (cpu_addr == `ADDR_CLR_IRECV); // [R11] [R19]
    // start writes ignore cpu_wdata entirely
    assign start_send  = cpu_wr && (cpu_addr == `ADDR_STAT_SEND) && dma_enable_bit; // [R12] [R14]
    assign start_trecv = cpu_wr && (cpu_addr == `ADDR_TRECV) && dma_enable_bit && responder_role; // [R15]
    assign start_irecv = cpu_wr && (cpu_addr == `ADDR_CLR_IRECV) && dma_enable_bit && !responder_role; // [R16]

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            phase_reg <= `PHASE_RESET;
        end else if (clk_en && wr_phase) begin
            phase_reg <= cpu_wdata[3:0]; // [R20]
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            id_reg <= `ID_RESET;
        end else if (clk_en && wr_id) begin
            id_reg <= cpu_wdata;
        end
    end

    // event detection
    assign req_rise     = lines.req && !req_prev;
    assign phase_diff   = ({lines.msg, lines.cd, lines.io} != phase_reg[2:0]);
    assign mismatch_evt = !responder_role && dma_enable_bit && req_rise && phase_diff; // [R5]
    assign sel_cond     = !lines.bsy && lines.sel && ((lines.data & id_reg) != 8'h00); // [R9]
    assign sel_evt      = sel_cond && !sel_prev;
    // odd parity: asserted ones over data and parity must be odd
    assign par_bad      = !(^{lines.data, lines.par}); // [R8]
    assign par_evt      = sel_evt && parity_check_enable && par_bad; // [R10]
    assign busy_evt     = bsy_prev && !lines.bsy && (state_reg != scsi_regs_pkg::DMA_IDLE);
    assign any_evt      = sel_evt || mismatch_evt || par_evt || busy_evt;

    // set wins over the read-to-clear so no event is lost
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            if (any_evt) begin
                irq_reg <= 1'b1;
            end else if (clr_rd) begin
                irq_reg <= 1'b0; // [R11]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            parerr_reg  <= 1'b0;
            busyerr_reg <= 1'b0;
        end else if (clk_en) begin
            if (par_evt) begin
                parerr_reg <= 1'b1;
            end else if (clr_rd) begin
                parerr_reg <= 1'b0; // [R11]
            end
            if (busy_evt) begin
                busyerr_reg <= 1'b1;
            end else if (clr_rd) begin
                busyerr_reg <= 1'b0; // [R11]
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            mismatch_reg <= 1'b0;
        end else if (clk_en) begin
            if (mismatch_evt) begin
                mismatch_reg <= 1'b1; // [R5]
            end else if (clr_rd || start_send || start_irecv) begin
                mismatch_reg <= 1'b0;
            end
        end
    end

    // dma sequencing; a mismatch halts the transfer until restarted
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            scsi_regs_pkg::DMA_IDLE: begin
                if (start_send) begin
                    state_next = scsi_regs_pkg::DMA_SEND;
                end else if (start_trecv) begin
                    state_next = scsi_regs_pkg::DMA_TRECV;
                end else if (start_irecv) begin
                    state_next = scsi_regs_pkg::DMA_IRECV;
                end
            end
            scsi_regs_pkg::DMA_SEND: begin
                if (!dma_enable_bit || mismatch_evt || (pop && head.last)) begin
                    state_next = scsi_regs_pkg::DMA_IDLE;
                end
            end
            scsi_regs_pkg::DMA_TRECV,
            scsi_regs_pkg::DMA_IRECV: begin
                if (!dma_enable_bit || mismatch_evt) begin
                    state_next = scsi_regs_pkg::DMA_IDLE;
                end
            end
            default: begin
                state_next = scsi_regs_pkg::DMA_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            state_reg <= scsi_regs_pkg::DMA_IDLE;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    // two-entry send buffer
    assign fifo_empty = (count_reg == 2'd0);
    assign fifo_full  = (count_reg == 2'd2);
    assign dma_ready  = !fifo_full && clk_en;
    assign push       = dma_valid && dma_ready;
    assign head       = fifo_mem[rd_ptr_reg];
    // the bus handshake paces draining: ACK as responder, REQ as initiator
    assign hs_line    = responder_role ? lines.ack : lines.req;
    assign hs_rise    = hs_line && !hs_prev;
    assign pop        = clk_en && (state_reg == scsi_regs_pkg::DMA_SEND) && hs_rise && !fifo_empty;

    for (genvar i = 0; i < `FIFO_DEPTH; i++) begin : g_entry
        always_ff @(posedge clk or negedge rst_n_int) begin
            if (!rst_n_int) begin
                fifo_mem[i] <= '0;
            end else if (push && (wr_ptr_reg == 1'(i))) begin
                fifo_mem[i] <= '{last: dma_last, data: dma_data};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg  <= 2'd0;
        end else if (clk_en) begin
            if (push) begin
                wr_ptr_reg <= !wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= !rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'd1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'd1;
            end
        end
    end

    // output data register; the last flag rises as the final byte goes out
    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            sdb_reg       <= 8'h00;
            sdb_valid_reg <= 1'b0;
            last_byte_reg <= 1'b0;
        end else if (clk_en) begin
            if (pop) begin
                sdb_reg       <= head.data;
                sdb_valid_reg <= 1'b1;
            end else if (state_reg == scsi_regs_pkg::DMA_IDLE) begin
                sdb_valid_reg <= 1'b0;
            end
            if (pop && head.last) begin
                last_byte_reg <= 1'b1; // [R1]
            end else if (start_send) begin
                last_byte_reg <= 1'b0;
            end
        end
    end

    // line drivers; mismatch also releases data, but parity out is not gated
    assign sdb_out             = sdb_reg;
    assign sdb_oe_n            = !(sdb_valid_reg && !mismatch_reg && (responder_role || !lines.io));
    assign bus_parity_line_out = ~^sdb_reg; // [R8]
    assign req_oe_n            = !(responder_role && phase_reg[`PH_REQ_BIT]); // [R2] [R17]
    assign msg_oe_n            = !(responder_role && phase_reg[2]); // [R3] [R17]
    assign cd_oe_n             = !(responder_role && phase_reg[1]); // [R3] [R17]
    assign io_oe_n             = !(responder_role && phase_reg[0]); // [R4] [R17]
    assign interrupt_out       = irq_reg;
    assign dma_state           = state_reg;
    assign dma_burst_active    = burst_dma && (state_reg != scsi_regs_pkg::DMA_IDLE);

    // live view, not latched
    assign bus_status = {lines.rst, lines.bsy, lines.req, lines.msg,
                         lines.cd, lines.io, lines.sel, lines.par}; // [R6] [R7]

    always_comb begin
        dma_status                  = 8'h00;
        dma_status[`ST_PARERR_BIT]  = parerr_reg;
        dma_status[`ST_IRQ_BIT]     = irq_reg;
        dma_status[`ST_MATCH_BIT]   = !phase_diff;
        dma_status[`ST_BUSYERR_BIT] = busyerr_reg;
        dma_status[`ST_ACTIVE_BIT]  = (state_reg != scsi_regs_pkg::DMA_IDLE);
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            rdata_reg <= 8'h00;
        end else if (clk_en && cpu_rd) begin
            case (cpu_addr)
                `ADDR_PHASE:     rdata_reg <= {last_byte_reg, 3'b000, phase_reg}; // [R1] [R20]
                `ADDR_BUS_ID:    rdata_reg <= bus_status; // [R19]
                `ADDR_STAT_SEND: rdata_reg <= dma_status;
                default:         rdata_reg <= 8'h00;
            endcase
        end
    end
    assign cpu_rdata = rdata_reg;

    property p_last_sent;
        @(posedge clk) disable iff (!rst_n_int)
        (pop && head.last) |=> last_byte_reg && (state_reg == scsi_regs_pkg::DMA_IDLE);
    endproperty
    a_last_sent: assert property (p_last_sent) else $error("last byte flag missing"); // [R1]

    property p_req_write;
        @(posedge clk) disable iff (!rst_n_int)
        (clk_en && wr_phase) |=> (req_oe_n == !($past(cpu_wdata[3]) && responder_role));
    endproperty
    a_req_write: assert property (p_req_write) else $error("req drive wrong"); // [R2]

    property p_io_role;
        @(posedge clk) disable iff (!rst_n_int)
        !responder_role |-> io_oe_n && cd_oe_n && msg_oe_n && req_oe_n;
    endproperty
    a_io_role: assert property (p_io_role) else $error("phase line driven as initiator"); // [R4]

    property p_mismatch;
        @(posedge clk) disable iff (!rst_n_int)
        (clk_en && mismatch_evt) |=> interrupt_out && mismatch_reg && sdb_oe_n;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mismatch not flagged"); // [R5]

    property p_bus_read;
        @(posedge clk) disable iff (!rst_n_int)
        (clk_en && cpu_rd && cpu_addr == `ADDR_BUS_ID) |=> cpu_rdata == $past(bus_status);
    endproperty
    a_bus_read: assert property (p_bus_read) else $error("bus status read wrong"); // [R7]

    property p_select;
        @(posedge clk) disable iff (!rst_n_int)
        (clk_en && sel_evt) |=> interrupt_out;
    endproperty
    a_select: assert property (p_select) else $error("selection interrupt missing"); // [R9]

    property p_parity;
        @(posedge clk) disable iff (!rst_n_int)
        (clk_en && sel_evt && !parity_check_enable && !parerr_reg && !clr_rd) |=> !parerr_reg;
    endproperty
    a_parity: assert property (p_parity) else $error("parity flagged while unchecked"); // [R10]

    property p_clear;
        @(posedge clk) disable iff (!rst_n_int)
        (clk_en && clr_rd && !any_evt) |=> !interrupt_out && !parerr_reg && !busyerr_reg && cpu_rdata == 8'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("read clear failed"); // [R11]

    property p_trecv_role;
        @(posedge clk) disable iff (!rst_n_int)
        (clk_en && state_reg == scsi_regs_pkg::DMA_IDLE && cpu_wr && cpu_addr == `ADDR_TRECV
            && !responder_role) |=> state_reg == scsi_regs_pkg::DMA_IDLE;
    endproperty
    a_trecv_role: assert property (p_trecv_role) else $error("receive started in wrong role"); // [R15]

    property p_phase_pad;
        @(posedge clk) disable iff (!rst_n_int)
        (clk_en && cpu_rd && cpu_addr == `ADDR_PHASE) |=> cpu_rdata[6:4] == 3'b000;
    endproperty
    a_phase_pad: assert property (p_phase_pad) else $error("unused phase bits not zero"); // [R20]

    property p_full;
        @(posedge clk) disable iff (!rst_n_int)
        fifo_full |-> !dma_ready ##1 (count_reg != 2'd3);
    endproperty
    a_full: assert property (p_full) else $error("buffer overfilled"); // [R14]

endmodule
